/* hw/kpi_pkg.sv */
// Package: constants for the keyboard pin interrupt block
package kpi_pkg;
  localparam int KPI_NUM_INPUTS = 8;
  localparam logic [7:0] KPI_FIXED_POL_MASK = 8'h0f;
  localparam logic [7:0] KPI_ANALOG_MASK = 8'he0;
  // Register offsets on the plain register port
  localparam logic [3:0] KPI_ADDR_CTRL = 4'h0;
  localparam logic [3:0] KPI_ADDR_PIN_EN = 4'h1;
  localparam logic [3:0] KPI_ADDR_PORT_DIR = 4'h2;
  localparam logic [3:0] KPI_ADDR_PORT_PULL = 4'h3;
  localparam logic [3:0] KPI_ADDR_PORT_OUT = 4'h4;
  localparam logic [3:0] KPI_ADDR_PORT_IN = 4'h5;
  localparam logic [3:0] KPI_ADDR_ANALOG_SEL = 4'h6;
  // Control register fields
  localparam int KPI_CTRL_POL_LSB = 4;
  localparam int KPI_CTRL_FLAG_BIT = 3;
  localparam int KPI_CTRL_ACK_BIT = 2;
  localparam int KPI_CTRL_IRQ_EN_BIT = 1;
  localparam int KPI_CTRL_MODE_BIT = 0;
  localparam logic [7:0] KPI_RESET_BYTE = 8'h00;
endpackage : kpi_pkg

/* hw/kpi_sync.sv */
// Two-flop synchroniser for the eight pin inputs
`timescale 1ns/10ps
module kpi_sync
  import kpi_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] async_in,
  output logic [7:0] sync_out
);
  logic [7:0] meta_r;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= KPI_RESET_BYTE;
      sync_out <= KPI_RESET_BYTE;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : kpi_sync

/* hw/kpi_top.sv */
// Keyboard pin interrupt block with shared port pin control
// Operation
// - One keyboard unit, eight inputs sharing pins with port lines.
// - Enabled keyboard input forces its pin to input direction.
// - Port pull enable still decides pull connection when enabled.
// - Pin level readable through port data when direction bit is input.
// - Analog selection disables port, keyboard and pull resistor.
// - Inputs six and five share analog pins like input seven.
// - Inputs four to zero have no analog sharing.
// - Inputs three to zero are fixed falling/low sensitive.
// - Inputs seven to four have selectable polarity.
// - Rising polarity with pull enable gives a pulldown.
// - Pull resistor truth table over pull, direction, enable, polarity.
// - Software picks edge-only or edge-and-level detection.
// - One shared flag and one interrupt enable for all inputs.
// - Keyboard event wakes from deepest stop and from wait.
// - Edge is deasserted one cycle then asserted the next.
// - Acknowledge clears flag; level mode holds it while asserted.
// - Interrupt requested while enable and flag are both one.
// - In deepest stop, enabled inputs wake asynchronously by level.
`timescale 1ns/10ps
module kpi_top
  import kpi_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n_out,
  output logic [7:0] pullup_en_out,
  output logic [7:0] pulldown_en_out,
  output logic [2:0] analog_connect_out,
  input wire logic deepest_clock_stop_mode_in,
  input wire logic wait_mode_in,
  output logic kbd_irq_out,
  output logic wake_out
);
  logic [7:0] pin_sync;
  logic [7:0] pin_prev_r;
  logic [7:0] kbd_pin_enable_r;
  logic [7:0] port_dir_r;
  logic [7:0] port_pull_r;
  logic [7:0] port_out_r;
  logic [2:0] analog_sel_r;
  logic [3:0] kbd_polarity_r;
  logic kbd_irq_enable_r;
  logic kbd_detect_mode_r;
  logic kbd_event_flag_r;
  logic kbd_event_flag_nxt;
  logic [7:0] analog_full;
  logic [7:0] kbd_active;
  logic [7:0] port_active;
  logic [7:0] rising_pol;
  logic [7:0] asserted_now;
  logic [7:0] asserted_prev;
  logic [7:0] edge_hit;
  logic any_level;
  logic ack_wr;
  logic [7:0] reg_rdata_nxt;

  // Normalise a pin level so that one means asserted
  function automatic logic [7:0] kpi_assert_lvl(input logic [7:0] lvl,
                                                input logic [7:0] pol);
    kpi_assert_lvl = ~(lvl ^ pol);
  endfunction : kpi_assert_lvl

  // Asserted and enabled lines, for the clocked and the stopped path
  function automatic logic [7:0] kpi_live_hits(input logic [7:0] lvl,
                                               input logic [7:0] pol,
                                               input logic [7:0] act);
    kpi_live_hits = kpi_assert_lvl(lvl, pol) & act;
  endfunction : kpi_live_hits

  // One decode shared by every register write
  function automatic logic kpi_wr_hit(input logic wr,
                                      input logic [3:0] addr,
                                      input logic [3:0] target);
    kpi_wr_hit = wr && (addr == target);
  endfunction : kpi_wr_hit

  // Input lines show the pin, output lines their latch
  function automatic logic [7:0] kpi_port_view(input logic [7:0] lvl,
                                               input logic [7:0] latch,
                                               input logic [7:0] dir,
                                               input logic [7:0] live);
    kpi_port_view = ((lvl & ~dir) | (latch & dir)) & live;
  endfunction : kpi_port_view

  kpi_sync u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // Only lines seven, six and five carry analog sharing
  assign analog_full = {analog_sel_r, 5'h00};
  assign kbd_active = kbd_pin_enable_r & ~analog_full;
  assign port_active = ~analog_full;
  // Low four lines hard-wired to falling/low
  assign rising_pol = {kbd_polarity_r, 4'h0};

  // Pin driver: keyboard enable overrides direction
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_out <= KPI_RESET_BYTE;
    end else begin
      pin_out <= port_out_r;
    end
  end
  assign pin_oe_n_out = ~(port_dir_r & ~kbd_active & port_active);
  assign analog_connect_out = analog_sel_r;

  // Pull-up: keyboard polarity on enabled lines, direction elsewhere
  always_comb begin
    pullup_en_out = KPI_RESET_BYTE;
    for (int i = 0; i < KPI_NUM_INPUTS; i++) begin
      if (port_active[i] && port_pull_r[i]) begin
        if (kbd_active[i]) begin
          pullup_en_out[i] = ~rising_pol[i];
        end else begin
          // Output lines get no pull
          pullup_en_out[i] = ~port_dir_r[i];
        end
      end
    end
  end

  // Pull-down only ever on an enabled rising/high line
  always_comb begin
    pulldown_en_out = KPI_RESET_BYTE;
    for (int i = 0; i < KPI_NUM_INPUTS; i++) begin
      if (port_active[i] && port_pull_r[i] && kbd_active[i]) begin
        pulldown_en_out[i] = rising_pol[i];
      end
    end
  end

  // Edge detection on the synchronised pin levels
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_prev_r <= KPI_RESET_BYTE;
    end else begin
      pin_prev_r <= pin_sync;
    end
  end
  assign asserted_now = kpi_live_hits(pin_sync, rising_pol, kbd_active);
  // Prev left unmasked; the now-term already gates by enable
  assign asserted_prev = kpi_assert_lvl(pin_prev_r, rising_pol);
  assign edge_hit = asserted_now & ~asserted_prev;
  assign any_level = |asserted_now;

  // Writing one to acknowledge clears the flag
  assign ack_wr = kpi_wr_hit(reg_wr_in, reg_addr_in, KPI_ADDR_CTRL) &&
                  reg_wdata_in[KPI_CTRL_ACK_BIT];

  // Flag: a set in the same cycle as an acknowledge wins
  always_comb begin
    kbd_event_flag_nxt = kbd_event_flag_r;
    if (ack_wr) begin
      kbd_event_flag_nxt = 1'b0;
    end
    if (|edge_hit) begin
      kbd_event_flag_nxt = 1'b1;
    end
    if (kbd_detect_mode_r && any_level) begin
      kbd_event_flag_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      kbd_event_flag_r <= 1'b0;
    end else begin
      kbd_event_flag_r <= kbd_event_flag_nxt;
    end
  end

  assign kbd_irq_out = kbd_irq_enable_r & kbd_event_flag_r;

  // Clocks are stopped in deepest stop, so the raw pins wake directly
  always_comb begin
    wake_out = 1'b0;
    if (deepest_clock_stop_mode_in) begin
      wake_out = |kpi_live_hits(pin_in, rising_pol, kbd_active);
    end else if (wait_mode_in) begin
      // Clocks run in wait, so the flag path suffices
      wake_out = kbd_irq_out;
    end
  end

  // Polarity of inputs seven to four
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      kbd_polarity_r <= 4'h0;
    end else if (kpi_wr_hit(reg_wr_in, reg_addr_in, KPI_ADDR_CTRL)) begin
      kbd_polarity_r <= reg_wdata_in[7:KPI_CTRL_POL_LSB];
    end
  end

  // Interrupt enable; the flag itself is read-only
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      kbd_irq_enable_r <= 1'b0;
    end else if (kpi_wr_hit(reg_wr_in, reg_addr_in, KPI_ADDR_CTRL)) begin
      kbd_irq_enable_r <= reg_wdata_in[KPI_CTRL_IRQ_EN_BIT];
    end
  end

  // Edge-only or edge-and-level detection
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      kbd_detect_mode_r <= 1'b0;
    end else if (kpi_wr_hit(reg_wr_in, reg_addr_in, KPI_ADDR_CTRL)) begin
      kbd_detect_mode_r <= reg_wdata_in[KPI_CTRL_MODE_BIT];
    end
  end

  // Keyboard pin enables
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      kbd_pin_enable_r <= KPI_RESET_BYTE;
    end else if (kpi_wr_hit(reg_wr_in, reg_addr_in, KPI_ADDR_PIN_EN)) begin
      kbd_pin_enable_r <= reg_wdata_in;
    end
  end

  // Port direction, one means output
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      port_dir_r <= KPI_RESET_BYTE;
    end else if (kpi_wr_hit(reg_wr_in, reg_addr_in, KPI_ADDR_PORT_DIR)) begin
      port_dir_r <= reg_wdata_in;
    end
  end

  // Port pull enables
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      port_pull_r <= KPI_RESET_BYTE;
    end else if (kpi_wr_hit(reg_wr_in, reg_addr_in, KPI_ADDR_PORT_PULL)) begin
      port_pull_r <= reg_wdata_in;
    end
  end

  // Port output latch
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      port_out_r <= KPI_RESET_BYTE;
    end else if (kpi_wr_hit(reg_wr_in, reg_addr_in, KPI_ADDR_PORT_OUT)) begin
      port_out_r <= reg_wdata_in;
    end
  end

  // Converter select for lines seven, six and five
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      analog_sel_r <= 3'h0;
    end else if (kpi_wr_hit(reg_wr_in, reg_addr_in, KPI_ADDR_ANALOG_SEL)) begin
      // Only three lines can reach the converter
      analog_sel_r <= reg_wdata_in[2:0];
    end
  end

  // Read mux; the strobe alone decides whether data stand
  always_comb begin
    reg_rdata_nxt = KPI_RESET_BYTE;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        // Acknowledge is write-only and reads as zero
        KPI_ADDR_CTRL: begin
          reg_rdata_nxt = {kbd_polarity_r, kbd_event_flag_r, 1'b0,
                           kbd_irq_enable_r, kbd_detect_mode_r};
        end
        KPI_ADDR_PIN_EN: reg_rdata_nxt = kbd_pin_enable_r;
        KPI_ADDR_PORT_DIR: reg_rdata_nxt = port_dir_r;
        KPI_ADDR_PORT_PULL: reg_rdata_nxt = port_pull_r;
        KPI_ADDR_PORT_OUT: reg_rdata_nxt = port_out_r;
        // Analog lines read as zero
        KPI_ADDR_PORT_IN: begin
          reg_rdata_nxt = kpi_port_view(pin_sync, port_out_r, port_dir_r,
                                        port_active);
        end
        KPI_ADDR_ANALOG_SEL: reg_rdata_nxt = {5'h00, analog_sel_r};
        // Unmapped indices read as zero
        default: reg_rdata_nxt = KPI_RESET_BYTE;
      endcase
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= KPI_RESET_BYTE;
    end else begin
      reg_rdata_out <= reg_rdata_nxt;
    end
  end
endmodule : kpi_top

/* verif/kpi_monitor.sv */
// Port checker for the keyboard pin interrupt block
`timescale 1ns/10ps
module kpi_monitor
  import kpi_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [7:0] pin_oe_n_out,
  input wire logic [7:0] pullup_en_out,
  input wire logic [7:0] pulldown_en_out,
  input wire logic [2:0] analog_connect_out,
  input wire logic deepest_clock_stop_mode_in,
  input wire logic wait_mode_in,
  input wire logic kbd_irq_out,
  input wire logic wake_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence ctrl_rd_s;
    reg_rd_in && reg_addr_in == KPI_ADDR_CTRL;
  endsequence
  ack_zero_a: assert property (ctrl_rd_s |=> !reg_rdata_out[2])
    else $error("ack bit read back as one");
  // Irq must mirror flag and enable seen by the same read
  irq_flag_a: assert property (ctrl_rd_s |=>
    (reg_rdata_out[3] && reg_rdata_out[1]) == $past(kbd_irq_out))
    else $error("irq differs from flag and enable");
  fixed_pol_a: assert property (pulldown_en_out[3:0] == 4'h0)
    else $error("pulldown on fixed polarity input");
  pull_excl_a: assert property ((pullup_en_out & pulldown_en_out) == 8'h00)
    else $error("pullup and pulldown together");
  analog_off_a: assert property ((analog_connect_out & (pullup_en_out[7:5] |
    pulldown_en_out[7:5] | ~pin_oe_n_out[7:5])) == 3'h0)
    else $error("analog pin still driven or pulled");
  drive_pull_a: assert property ((~pin_oe_n_out &
    (pullup_en_out | pulldown_en_out)) == 8'h00)
    else $error("pull on driven pin");
  wake_wait_a: assert property (wait_mode_in && !deepest_clock_stop_mode_in
    |-> wake_out == kbd_irq_out) else $error("wait wake differs from irq");
  wake_idle_a: assert property (!wait_mode_in && !deepest_clock_stop_mode_in
    |-> !wake_out) else $error("wake while running");
endmodule : kpi_monitor

bind kpi_top kpi_monitor kpi_monitor_inst (.clk_in, .sys_rst_in, .reg_addr_in,
  .reg_rd_in, .reg_rdata_out, .pin_oe_n_out, .pullup_en_out, .pulldown_en_out,
  .analog_connect_out, .deepest_clock_stop_mode_in, .wait_mode_in,
  .kbd_irq_out, .wake_out);

/* verif/kpi_keys.sv */
// Model of the key switches driving the eight shared pins
`timescale 1ns/10ps
module kpi_keys (
  input wire logic [7:0] key_lvl_in,
  input wire logic [7:0] drv_in,
  input wire logic [7:0] drv_oe_n_in,
  output logic [7:0] pin_out
);
  // Device drive wins over a key, so contention never hides a fault
  assign pin_out = (~drv_oe_n_in & drv_in) | (drv_oe_n_in & key_lvl_in);
endmodule : kpi_keys

/* verif/tb_kpi_top.sv */
// Self-checking bench for the keyboard pin interrupt block
`timescale 1ns/10ps
module tb_kpi_top
  import kpi_pkg::*;
;
  logic clk_in = 1'h0, sys_rst_in = 1'h1, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
  logic deepest_clock_stop_mode_in = 1'h0, wait_mode_in = 1'h0;
  logic kbd_irq_out, wake_out, a;
  logic [3:0] reg_addr_in = 4'h0, p4;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, pin_in, pin_out, pin_oe_n_out;
  logic [7:0] pullup_en_out, pulldown_en_out, key_lvl = 8'hff, en, dd, pe, po;
  logic [7:0] an, ky;
  logic [31:0] r;
  logic [2:0] analog_connect_out;
  int error_cnt = 0, checks = 0;
  kpi_top kpi_top_inst (.clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pin_in, .pin_out, .pin_oe_n_out,
    .pullup_en_out, .pulldown_en_out, .analog_connect_out, .wait_mode_in,
    .deepest_clock_stop_mode_in, .kbd_irq_out, .wake_out);
  kpi_keys kpi_keys_inst (.key_lvl_in(key_lvl), .drv_in(pin_out),
    .drv_oe_n_in(pin_oe_n_out), .pin_out(pin_in));
  always #5 clk_in = ~clk_in;
  function automatic logic [7:0] ctl(logic [3:0] p, logic ack, logic m);
    return {p, 1'h0, ack, 1'h1, m};
  endfunction : ctl
  function automatic logic [7:0] exp_pull(logic dn);
    return dn ? ~an & pe & en & po : ~an & pe & (~en & ~dd | en & ~po);
  endfunction : exp_pull
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic w(int c);
    repeat (c) @(negedge clk_in);
  endtask : w
  task automatic wr(logic [3:0] ad, logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= ad;
    reg_wdata_in <= d;
    reg_wr_in <= 1'h1;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rc(logic [3:0] ad, logic [7:0] e);
    @(posedge clk_in);
    reg_addr_in <= ad;
    reg_rd_in <= 1'h1;
    @(posedge clk_in);
    reg_rd_in <= 1'h0;
    w(1);
    cmp("rdata", e, reg_rdata_out);
  endtask : rc
  initial begin
    #200us;
    error_cnt++;
    end_sim();
  end
  initial begin
    r = $urandom(43);
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    for (int i = 0; i < 16; i++) rc(i[3:0], i == 5 ? 8'hff : 8'h00);
    $display("test reset done");
    for (int k = 0; k < 20; k++) begin
      {en, dd, pe, ky} = $urandom;
      r = $urandom;
      po = {r[3:0], 4'h0};
      an = {r[6:4], 5'h00};
      if (k == 0) {en, dd, pe, po, an} = 40'hffffff_f0_00;
      wr(KPI_ADDR_CTRL, ctl(po[7:4], 1'h1, 1'h0));
      wr(KPI_ADDR_PIN_EN, en);
      wr(KPI_ADDR_PORT_DIR, dd);
      wr(KPI_ADDR_PORT_PULL, pe);
      wr(KPI_ADDR_PORT_OUT, ky);
      wr(KPI_ADDR_ANALOG_SEL, {5'h00, an[7:5]});
      @(posedge clk_in) key_lvl <= ~ky;
      w(4);
      cmp("up", exp_pull(1'h0), pullup_en_out);
      cmp("dn", exp_pull(1'h1), pulldown_en_out);
      cmp("oe_n", ~(dd & ~en & ~an), pin_oe_n_out);
      cmp("ana", {5'h00, an[7:5]}, {5'h00, analog_connect_out});
      cmp("out", ky, pin_out);
      rc(KPI_ADDR_PORT_IN, ~an & (dd & ky | ~dd & ~ky));
    end
    $display("test pins done");
    wr(KPI_ADDR_ANALOG_SEL, 8'h00);
    wr(KPI_ADDR_PORT_DIR, 8'h00);
    for (int n = 0; n < 8; n++) begin
      r = $urandom;
      a = n > 3 && r[0];
      p4 = {4{a}};
      @(posedge clk_in) key_lvl <= {8{~a}};
      wr(KPI_ADDR_CTRL, ctl(p4, 1'h1, 1'h0));
      wr(KPI_ADDR_PIN_EN, 8'h01 << n);
      w(4);
      wr(KPI_ADDR_CTRL, ctl(p4, 1'h1, 1'h0));
      w(2);
      cmp("irq", 8'h00, kbd_irq_out);
      @(posedge clk_in) key_lvl[n] <= a;
      w(5);
      cmp("irq", 8'h01, kbd_irq_out);
      rc(KPI_ADDR_CTRL, {p4, 4'ha});
      wr(KPI_ADDR_CTRL, ctl(p4, 1'h1, 1'h0));
      w(2);
      cmp("irq", 8'h00, kbd_irq_out);
      @(posedge clk_in) deepest_clock_stop_mode_in <= 1'h1;
      w(1);
      cmp("wake", 8'h01, wake_out);
      @(posedge clk_in) {deepest_clock_stop_mode_in, wait_mode_in} <= 2'h1;
      wr(KPI_ADDR_CTRL, ctl(p4, 1'h1, 1'h1));
      w(3);
      cmp("irq", 8'h01, kbd_irq_out);
      cmp("wake", 8'h01, wake_out);
      wr(KPI_ADDR_CTRL, ctl(p4, 1'h1, 1'h1));
      w(2);
      cmp("irq", 8'h01, kbd_irq_out);
      @(posedge clk_in) key_lvl[n] <= ~a;
      w(4);
      wr(KPI_ADDR_CTRL, ctl(p4, 1'h1, 1'h1));
      w(2);
      cmp("irq", 8'h00, kbd_irq_out);
      @(posedge clk_in) wait_mode_in <= 1'h0;
    end
    $display("test events done");
    end_sim();
  end
endmodule : tb_kpi_top
